// >>> umcd_pkg.sv
// Constants, codes and carrier types for the channel command decoder.
// Assumes a 20 MHz pclk and software access over APB with 32-bit data.
// Behaviour
// - Code 0001 returns the mode register pointer to the first mode register.
// - Code 0010 resets receiver: disabled, receive FIFO flushed.
// - Code 0011 resets the transmitter as a hardware reset would.
// - Code 0100 clears status bits 7 to 4 (break, framing, parity, overrun).
// - Code 0101 clears the break-change interrupt status bit.
// - Code 0110 starts break after transmitter drains, within two bit times.
// - Start break is ignored unless the transmitter is enabled.
// - Code 0111 ends break within two bit times, then one mark bit.
// - Code 1000 drives request-to-send low, 1001 drives it high.
// - In time-out mode each received character restarts the counter.
// - Entering time-out selects counter mode, blocks commands, stops, clears ready.
// - Code 1011 sets the mode register pointer to zero.
// - Code 1100 ends time-out mode without stopping counter or clearing flags.
// - Code 1110 stops the oscillator, keeping all register contents.
// - Only power-down exit executes while the oscillator is stopped.
// - Code 1111 restarts oscillator; host waits for start-up.
// - Power-down codes are decoded in channel A command register only.
// - One write may carry several commands only if they do not conflict.
// - Channel B decodes the same codes, with 0xE and 0xF unused.
package umcd_pkg;
   localparam logic [7:0] ADDR_CMD_A   = 8'h00;
   localparam logic [7:0] ADDR_CMD_B   = 8'h04;
   localparam logic [7:0] ADDR_STAT_A  = 8'h08;
   localparam logic [7:0] ADDR_STAT_B  = 8'h0C;
   localparam logic [7:0] ADDR_EVENT   = 8'h10;
   localparam logic [7:0] ADDR_TOP     = 8'h14;
   localparam logic [3:0] CMD_NONE     = 4'h0;
   localparam logic [3:0] CMD_MRP_ONE  = 4'h1;
   localparam logic [3:0] CMD_RX_RST   = 4'h2;
   localparam logic [3:0] CMD_TX_RST   = 4'h3;
   localparam logic [3:0] CMD_ERR_RST  = 4'h4;
   localparam logic [3:0] CMD_BRK_CLR  = 4'h5;
   localparam logic [3:0] CMD_BRK_ON   = 4'h6;
   localparam logic [3:0] CMD_BRK_OFF  = 4'h7;
   localparam logic [3:0] CMD_RTS_ON   = 4'h8;
   localparam logic [3:0] CMD_RTS_OFF  = 4'h9;
   localparam logic [3:0] CMD_TO_ON    = 4'hA;
   localparam logic [3:0] CMD_MRP_ZERO = 4'hB;
   localparam logic [3:0] CMD_TO_OFF   = 4'hC;
   localparam logic [3:0] CMD_PD_ON    = 4'hE;
   localparam logic [3:0] CMD_PD_OFF   = 4'hF;
   localparam logic [1:0] MRP_FIRST    = 2'h1;
   localparam logic [1:0] MRP_ZERO     = 2'h0;
   localparam int         ERR_LO       = 4;
   localparam int         ERR_HI       = 7;
   localparam int         BIT_CYC_W    = 16;
   // Bit time in pclk cycles; the real one comes from the baud generator
   localparam logic [15:0] BIT_CYC_DEF = 16'h0010;
   localparam logic [15:0] TWO_BITS    = 16'h0002;

   typedef enum logic [1:0] {
      BRK_IDLE = 2'b00,
      BRK_WAIT = 2'b01,
      BRK_ON   = 2'b10,
      BRK_MARK = 2'b11
   } umcd_brk_type;

   typedef struct packed {
      logic [1:0]   mrp;        // mode_register_pointer
      logic         rts_n;      // send_request_out_n
      logic         brk_out;    // 1 while the line is forced spacing
      umcd_brk_type brk;
      logic [15:0]  brk_cnt;
      logic [7:4]   err;        // status bits 7..4
      logic         brk_chg;    // break-change interrupt bit
      logic         to_mode;
      logic         rx_rst;     // one-cycle pulses to the datapath
      logic         tx_rst;
      logic         ct_restart;
   } umcd_chan_type;
endpackage

// >>> umcd_top.sv
// Miscellaneous command decoder for both channels, with an APB slave.
// Assumes the datapath reports transmitter state, break and error events
// as pclk-synchronous levels and pulses.
`timescale 1ns/1ps
module umcd_top
   import umcd_pkg::*;
(
   input  wire logic        pclk,          // 20 MHz clock
   input  wire logic        presetn,       // async reset, low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB access phase
   input  wire logic        pwrite,        // APB write
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error, unmapped address
   input  wire logic [1:0]  tx_enabled,    // transmitter enabled per chan
   input  wire logic [1:0]  tx_busy,       // char in shifter or FIFO
   input  wire logic [1:0]  rx_to_fifo,    // char moved into rx FIFO
   input  wire logic [7:0]  err_set,       // {B[7:4],A[7:4]} error events
   input  wire logic [1:0]  brk_chg_set,   // break change events
   output logic      [1:0]  serial_out_brk,// 1 forces serial out spacing
   output logic      [1:0]  tx_hold_mark,  // mark bit before next char
   output logic      [1:0]  send_request_out_n, // request-to-send, low
   output logic      [1:0]  rx_reset,      // receiver reset pulse
   output logic      [1:0]  tx_reset,      // transmitter reset pulse
   output logic      [1:0]  ct_restart,    // counter restart pulse
   output logic      [1:0]  timeout_mode,  // counter under time-out control
   output logic             osc_stop       // oscillator stopped
);
   typedef struct packed {
      umcd_chan_type [1:0] ch;
      logic                osc_stop;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      logic [1:0]          hold_mark;  // registered copy of the mark phase
   } umcd_state_type;

   umcd_state_type s_q, s_d;

   function automatic logic [31:0] rd_stat(input umcd_chan_type c);
      rd_stat = {24'h000000, c.err, c.brk_chg, c.to_mode, c.mrp};
   endfunction

   logic acc;
   logic wr;
   logic [1:0] cmd_hit;
   logic [3:0] code;
   assign acc  = psel && !penable;
   assign wr   = acc && pwrite;
   // Lower nibble belongs to the enable/disable logic elsewhere
   assign code = pwdata[7:4];
   assign cmd_hit = {wr && paddr == ADDR_CMD_B, wr && paddr == ADDR_CMD_A};

   always_comb begin
      s_d = s_q;
      s_d.pready  = acc;
      s_d.pslverr = acc && paddr >= ADDR_TOP;
      s_d.prdata  = 32'h00000000;
      if (acc && !pwrite) begin
         case (paddr)
            ADDR_STAT_A: s_d.prdata = rd_stat(s_q.ch[0]);
            ADDR_STAT_B: s_d.prdata = rd_stat(s_q.ch[1]);
            ADDR_EVENT: s_d.prdata = {31'h00000000, s_q.osc_stop};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      // Power-down exit is decoded even with the oscillator stopped
      if (cmd_hit[0] && code == CMD_PD_OFF) begin
         s_d.osc_stop = 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
         s_d.ch[i].rx_rst     = 1'b0;
         s_d.ch[i].tx_rst     = 1'b0;
         s_d.ch[i].ct_restart = 1'b0;
         // Break sequencer first; commands below may override its step
         case (s_q.ch[i].brk)
            BRK_IDLE: s_d.ch[i].brk_cnt = 16'h0000;
            BRK_WAIT: begin
               if (!tx_busy[i]) begin
                  s_d.ch[i].brk_cnt = s_q.ch[i].brk_cnt + 16'h0001;
                  if (s_q.ch[i].brk_cnt >= BIT_CYC_DEF) begin
                     s_d.ch[i].brk     = BRK_ON;
                     s_d.ch[i].brk_out = 1'b1;
                     s_d.ch[i].brk_cnt = 16'h0000;
                  end
               end
            end
            BRK_ON: s_d.ch[i].brk_cnt = 16'h0000;
            BRK_MARK: begin
               s_d.ch[i].brk_cnt = s_q.ch[i].brk_cnt + 16'h0001;
               if (s_q.ch[i].brk_cnt >= BIT_CYC_DEF) begin
                  s_d.ch[i].brk = BRK_IDLE;
               end
            end
            default: s_d.ch[i].brk = BRK_IDLE;
         endcase
         if (cmd_hit[i] && !s_q.osc_stop) begin
            case (code)
               CMD_MRP_ONE: s_d.ch[i].mrp = MRP_FIRST;
               CMD_RX_RST: begin
                  s_d.ch[i].rx_rst = 1'b1;
                  s_d.ch[i].err    = 4'h0;
               end
               CMD_TX_RST: begin
                  s_d.ch[i].tx_rst  = 1'b1;
                  s_d.ch[i].brk     = BRK_IDLE;
                  s_d.ch[i].brk_out = 1'b0;
               end
               CMD_ERR_RST: s_d.ch[i].err = 4'h0;
               CMD_BRK_CLR: s_d.ch[i].brk_chg = 1'b0;
               CMD_BRK_ON: begin
                  if (tx_enabled[i] && s_q.ch[i].brk == BRK_IDLE) begin
                     s_d.ch[i].brk     = BRK_WAIT;
                     s_d.ch[i].brk_cnt = 16'h0000;
                  end
               end
               CMD_BRK_OFF: begin
                  if (s_q.ch[i].brk != BRK_IDLE) begin
                     s_d.ch[i].brk     = BRK_MARK;
                     s_d.ch[i].brk_out = 1'b0;
                     s_d.ch[i].brk_cnt = 16'h0000;
                  end
               end
               CMD_RTS_ON: s_d.ch[i].rts_n = 1'b0;
               CMD_RTS_OFF: s_d.ch[i].rts_n = 1'b1;
               CMD_TO_ON: s_d.ch[i].to_mode = 1'b1;
               CMD_MRP_ZERO: s_d.ch[i].mrp = MRP_ZERO;
               CMD_TO_OFF: s_d.ch[i].to_mode = 1'b0;
               CMD_PD_ON: begin
                  if (i == 0) begin
                     s_d.osc_stop = 1'b1;
                  end
               end
               default: ;
            endcase
         end
         // Event sets come last so they win over a same-cycle clear
         s_d.ch[i].err = s_d.ch[i].err | err_set[i*4 +: 4];
         if (brk_chg_set[i]) begin
            s_d.ch[i].brk_chg = 1'b1;
         end
         if (s_q.ch[i].to_mode && rx_to_fifo[i] && !s_q.osc_stop) begin
            s_d.ch[i].ct_restart = 1'b1;
         end
         // Kept as its own flop so the output needs no decode after it
         s_d.hold_mark[i] = s_d.ch[i].brk == BRK_MARK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ch[0].rts_n <= 1'b1;
         s_q.ch[1].rts_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Per-channel outputs (break, mark, request-to-send, pulses, time-out), derived from registered state
   generate
      for (genvar g = 0; g < 2; g++) begin : g_out
         assign serial_out_brk[g]     = s_q.ch[g].brk_out;
         assign tx_hold_mark[g]       = s_q.hold_mark[g];
         assign send_request_out_n[g] = s_q.ch[g].rts_n;
         assign rx_reset[g]           = s_q.ch[g].rx_rst;
         assign tx_reset[g]           = s_q.ch[g].tx_rst;
         assign ct_restart[g]         = s_q.ch[g].ct_restart;
         // Counter-mode select, block, stop and ready clear follow this
         assign timeout_mode[g]       = s_q.ch[g].to_mode;
      end
   endgenerate

   assign osc_stop = s_q.osc_stop;
   assign prdata   = s_q.prdata;
   assign pready   = s_q.pready;
   assign pslverr  = s_q.pslverr;
endmodule // umcd_top

// >>> umcd_sva.sv
// Checker for the command decoder ports, bound into umcd_top.
// Assumes one clock, pclk, and presetn as the asynchronous reset.
`timescale 1ns/1ps
module umcd_sva
   import umcd_pkg::*;
(
   input wire logic        pclk,               // clock
   input wire logic        presetn,            // reset, low
   input wire logic        psel,               // select
   input wire logic        penable,            // access phase
   input wire logic        pwrite,             // write
   input wire logic [7:0]  paddr,              // address
   input wire logic [31:0] pwdata,             // write data
   input wire logic        pready,             // ready
   input wire logic [1:0]  rx_to_fifo,         // char into FIFO
   input wire logic [1:0]  send_request_out_n, // request-to-send
   input wire logic [1:0]  rx_reset,           // receiver reset
   input wire logic [1:0]  ct_restart,         // counter restart
   input wire logic [1:0]  timeout_mode,       // time-out mode
   input wire logic        osc_stop            // oscillator off
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire       st = psel && !penable && pwrite;
   wire [3:0] c  = pwdata[7:4];
   wire       wa = st && paddr == ADDR_CMD_A && !osc_stop;
   wire       wb = st && paddr == ADDR_CMD_B;
   property p_rdy; psel && !penable |=> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rts; wa && c == CMD_RTS_ON |=> !send_request_out_n[0];
   endproperty
   a_rts: assert property (p_rts) else $error("rts not low");
   property p_rxr; wa && c == CMD_RX_RST |=> rx_reset[0] ##1 !rx_reset[0];
   endproperty
   a_rxr: assert property (p_rxr) else $error("rx reset pulse");
   property p_pd; wa && c == CMD_PD_ON |=> osc_stop;
   endproperty
   a_pd: assert property (p_pd) else $error("no power-down");
   property p_pdb; wb && c == CMD_PD_ON && !osc_stop |=> !osc_stop;
   endproperty
   a_pdb: assert property (p_pdb) else $error("b power-down");
   property p_lock;
      st && osc_stop && paddr == ADDR_CMD_A && c == CMD_RTS_ON
      |=> $stable(send_request_out_n);
   endproperty
   a_lock: assert property (p_lock) else $error("cmd while down");
   property p_to; wa && c == CMD_TO_ON |=> timeout_mode[0];
   endproperty
   a_to: assert property (p_to) else $error("no time-out mode");
   property p_tcr; timeout_mode[0] && rx_to_fifo[0] |-> ##[1:2] ct_restart[0];
   endproperty
   a_tcr: assert property (p_tcr) else $error("no restart");
endmodule // umcd_sva
bind umcd_top umcd_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .rx_to_fifo, .send_request_out_n, .rx_reset,
   .ct_restart, .timeout_mode, .osc_stop);

// >>> umcd_host.sv
// Host model: APB master writing commands and reading status.
// Assumes the slave raises pready in the access phase; waits are bounded.
`timescale 1ns/1ps
module umcd_host (
   input  wire logic        pclk,           // clock
   output logic             psel = 1'b0,    // select
   output logic             penable = 1'b0, // access phase
   output logic             pwrite = 1'b0,  // write
   output logic [7:0]       paddr = 8'h00,  // address
   output logic [31:0]      pwdata = 32'h0, // write data
   input  wire logic [31:0] prdata,         // read data
   input  wire logic        pready,         // ready
   input  wire logic        pslverr         // error
);
   logic [31:0] rdata;
   logic        rerr;
   int          hangs = 0;
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      // Two idle edges keep setups four edges apart
      repeat (2) @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) hangs++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
endmodule // umcd_host

// >>> test_uart_channel_misc_command_decoder.sv
// Self-checking bench for umcd_top; umcd_host issues the APB traffic.
// Assumes the sva checker is bound in by its own file.
`timescale 1ns/1ps
module test_uart_channel_misc_command_decoder;
   import umcd_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite;
   logic        pready, pslverr, osc_stop;
   logic [7:0]  paddr, err_set = 8'h00;
   logic [31:0] pwdata, prdata;
   logic [1:0]  tx_enabled = 2'b00, tx_busy = 2'b00, rx_to_fifo = 2'b00;
   logic [1:0]  brk_chg_set = 2'b00, serial_out_brk, tx_hold_mark;
   logic [1:0]  send_request_out_n, rx_reset, tx_reset, ct_restart;
   logic [1:0]  timeout_mode;
   logic [1:0]  seen_rx = 2'b00, seen_tx = 2'b00, seen_ct = 2'b00;
   int          failures = 0, n_compared = 0;
   always #25 pclk = ~pclk;
   // Pulses last one cycle; latch them so a later compare can see them
   always @(posedge pclk) begin
      seen_rx <= seen_rx | rx_reset;
      seen_tx <= seen_tx | tx_reset;
      seen_ct <= seen_ct | ct_restart;
   end
   umcd_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tx_enabled, .tx_busy, .rx_to_fifo,
      .err_set, .brk_chg_set, .serial_out_brk, .tx_hold_mark,
      .send_request_out_n, .rx_reset, .tx_reset, .ct_restart, .timeout_mode,
      .osc_stop);
   umcd_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic cmd(input logic [7:0] a, input logic [3:0] c);
      u_host.xfer(1'b1, a, {24'h0, c, 4'h0});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      u_host.xfer(1'b0, a, 32'h0);
      check(u_host.rdata, e);
   endtask
   task automatic wait_brk(input logic v);
      int n;
      for (n = 0; n < 33; n++) begin
         @(negedge pclk);
         if (serial_out_brk[0] === v) break;
      end
      check(32'(serial_out_brk[0]), 32'(v));
   endtask
   task automatic end_sim;
      failures += u_host.hangs;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      check(32'(send_request_out_n), 32'h3);
      cmd(ADDR_CMD_A, CMD_MRP_ONE);
      rd(ADDR_STAT_A, 32'h01);
      cmd(ADDR_CMD_A, CMD_MRP_ZERO);
      rd(ADDR_STAT_A, 32'h00);
      cmd(ADDR_CMD_B, CMD_MRP_ONE);
      @(posedge pclk);
      err_set <= 8'hFF;
      brk_chg_set <= 2'b11;
      @(posedge pclk);
      err_set <= 8'h00;
      brk_chg_set <= 2'b00;
      cmd(ADDR_CMD_A, CMD_NONE);
      cmd(ADDR_CMD_A, 4'hD);
      rd(ADDR_STAT_A, 32'hF8);
      cmd(ADDR_CMD_A, CMD_ERR_RST);
      rd(ADDR_STAT_A, 32'h08);
      cmd(ADDR_CMD_A, CMD_BRK_CLR);
      rd(ADDR_STAT_A, 32'h00);
      rd(ADDR_STAT_B, 32'hF9);
      cmd(ADDR_CMD_A, CMD_RTS_ON);
      check(32'(send_request_out_n), 32'h2);
      cmd(ADDR_CMD_A, CMD_RTS_OFF);
      check(32'(send_request_out_n), 32'h3);
      cmd(ADDR_CMD_A, CMD_TO_ON);
      rd(ADDR_STAT_A, 32'h04);
      check(32'(timeout_mode), 32'h1);
      @(posedge pclk);
      rx_to_fifo <= 2'b01;
      @(posedge pclk);
      rx_to_fifo <= 2'b00;
      cmd(ADDR_CMD_A, CMD_RX_RST);
      check(32'(seen_ct), 32'h1);
      check(32'(seen_rx), 32'h1);
      cmd(ADDR_CMD_A, CMD_TO_OFF);
      rd(ADDR_STAT_A, 32'h00);
      check(32'(timeout_mode), 32'h0);
      cmd(ADDR_CMD_A, CMD_BRK_ON);
      repeat (40) @(negedge pclk);
      check(32'(serial_out_brk), 32'h0);
      @(posedge pclk);
      tx_enabled <= 2'b11;
      tx_busy <= 2'b01;
      cmd(ADDR_CMD_A, CMD_BRK_ON);
      repeat (40) @(negedge pclk);
      check(32'(serial_out_brk), 32'h0);
      @(posedge pclk);
      tx_busy <= 2'b00;
      wait_brk(1'b1);
      cmd(ADDR_CMD_A, CMD_BRK_OFF);
      wait_brk(1'b0);
      check(32'(tx_hold_mark), 32'h1);
      cmd(ADDR_CMD_A, CMD_TX_RST);
      check(32'(seen_tx), 32'h1);
      check(32'(tx_hold_mark), 32'h0);
      u_host.xfer(1'b0, ADDR_TOP, 32'h0);
      check(32'(u_host.rerr), 32'h1);
      @(posedge pclk);
      tx_enabled <= 2'b00;
      cmd(ADDR_CMD_B, CMD_PD_ON);
      rd(ADDR_EVENT, 32'h0);
      cmd(ADDR_CMD_A, CMD_PD_ON);
      rd(ADDR_EVENT, 32'h1);
      rd(ADDR_STAT_B, 32'hF9);
      cmd(ADDR_CMD_A, CMD_RTS_ON);
      check(32'(send_request_out_n), 32'h3);
      cmd(ADDR_CMD_A, CMD_PD_OFF);
      rd(ADDR_EVENT, 32'h0);
      repeat (20) @(posedge pclk);
      end_sim();
   end
endmodule // test_uart_channel_misc_command_decoder
